/* File: rra_pkg.sv */
// Constants and carrier types of the remote register access parser
package rra_pkg;

  // ----------------------------------------------------------------
  // Datagram side
  // ----------------------------------------------------------------
  localparam logic [15:0] UDP_PORT     = 16'h6A2D;  // 27181 decimal

  // ----------------------------------------------------------------
  // Command word field positions
  // ----------------------------------------------------------------
  localparam int CMD_WRITE_BIT = 15;
  localparam int CMD_ADDR_BIT  = 14;
  localparam int CMD_INFO_BIT  = 13;
  localparam int CMD_SPACE_HI  = 12;
  localparam int CMD_SPACE_LO  = 10;
  localparam int CMD_SIZE_HI   = 9;
  localparam int CMD_SIZE_LO   = 8;
  localparam int CMD_INC_BIT   = 7;
  localparam int CMD_COUNT_HI  = 6;

  localparam logic [1:0] SZ_8  = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;
  localparam logic [1:0] SZ_64 = 2'h3;

  // ----------------------------------------------------------------
  // Info area
  // ----------------------------------------------------------------
  localparam logic [15:0] COOKIE_BASE  = 16'h5A00;
  localparam logic [6:0]  TYPE_REG     = 7'h01;
  localparam logic [6:0]  TYPE_MEM     = 7'h02;
  localparam logic [6:0]  TYPE_EEPROM  = 7'h0E;
  localparam logic [6:0]  TYPE_FLASH   = 7'h0F;

  // Size descriptor: writable, type, access width mask; index = space
  localparam logic [7:0][15:0] SPACE_SIZES = {
    16'h0000, {1'b1, TYPE_REG, 8'h02}, 16'h0000, 16'h0000,
    16'h0000, {1'b1, TYPE_EEPROM, 8'h02}, {1'b1, TYPE_REG, 8'h02},
    {1'b1, TYPE_REG, 8'h04}};
  // Range descriptor: erase, page and address range exponents
  localparam logic [7:0][15:0] SPACE_RANGES = {
    16'h0000, 16'h0005, 16'h0000, 16'h0000,
    16'h0000, 16'h0007, 16'h0008, 16'h0010};
  // Space labels, first character in the low byte
  localparam logic [7:0][63:0] SPACE_LABELS = {
    64'h0, 64'h2020535554415453, 64'h0, 64'h0,
    64'h0, 64'h4D5250454554454E, 64'h205049484354454E, 64'h2020534745524F49};

  // ----------------------------------------------------------------
  // Write enable key and configuration EEPROM
  // ----------------------------------------------------------------
  localparam logic [2:0]  KEY_SPACE    = 3'h6;
  localparam logic [15:0] KEY_OFFSET   = 16'h001A;
  localparam logic [15:0] KEY_VALUE    = 16'h5A02;
  localparam logic [15:0] KEY_RESET    = 16'h0000;
  localparam logic [2:0]  EE_SPACE     = 3'h2;
  localparam logic [15:0] EE_RO_LIMIT  = 16'h0020;
  localparam logic [2:0]  REG_SPACE    = 3'h0;
  localparam logic [2:0]  NET_SPACE    = 3'h1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sop;
    logic        eop;
    logic [15:0] dst_port;
    logic [15:0] src_port;
    logic [7:0]  data;
  } rra_rx_t;

  typedef struct packed {
    logic [15:0] port;
    logic [7:0]  data;
  } rra_tx_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [2:0]  space;
    logic [1:0]  size;
    logic [15:0] addr;
    logic [63:0] wdata;
  } rra_acc_t;

endpackage

/* File: rra_parser.sv */
// Remote register access command parser
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Command word is 16 bits: write, address, info, space, size, increment, count.
// R2: Top command bit set means write, clear means read.
// R3: Address bit set loads next word into that space's own pointer.
// R4: Info bit clear targets the space, set targets its info area.
// R5: Three-bit selector picks one of eight address spaces.
// R6: Size code 0..3 means 8, 16, 32 or 64 bit elements.
// R7: Increment bit advances pointer by element bytes; clear keeps it fixed.
// R8: Count of 1..127 elements; zero count is an error.
// R9: Host sends optional address after reads, optional address then data after writes.
// R10: Byte addresses; all words travel least significant byte first.
// R11: Info area is read-only; first word is check value 5A0N.
// R12: Info offsets hold sizes, ranges, pointer, then four label words.
// R13: Info area allows 16-bit reads only.
// R14: Sizes word top bit is writable, bits 14:8 the space type.
// R15: Sizes word low four bits are the allowed access width mask.
// R16: Ranges word holds erase, page and range exponents.
// R17: Space zero is a 64 KiB register range with 32-bit access.
// R18: Space one reaches network chip registers, 16-bit accesses only.
// R19: Space two EEPROM is 16-bit; first 32 bytes read-only.
// R20: EEPROM writes happen only while the key register holds 5A02.
// R21: Key register clears at the end of every received packet.
// R22: Host places a read after EEPROM writes for synchronisation.
// R23: Only datagrams to the fixed destination port are accepted.
// R24: Reply goes to the source port of the request.
// R25: Commands run in order; read results join one reply in order.
module rra_parser (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             rx_valid,
  input  wire rra_pkg::rra_rx_t rx,
  output logic                  rx_ready,
  output logic                  tx_valid,
  output rra_pkg::rra_tx_t      tx,
  input  wire logic             tx_ready,
  output logic                  tx_end,
  output rra_pkg::rra_acc_t     acc,
  input  wire logic             acc_ack,
  input  wire logic [63:0]      acc_rdata,
  output logic                  cmd_error
);
  import rra_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CMD_LO, S_CMD_HI, S_ADR_LO, S_ADR_HI, S_WDATA,
    S_EXEC, S_WAIT, S_SEND, S_NEXT, S_DRAIN, S_END
  } rra_state_t;

  typedef struct packed {
    rra_state_t       st;
    logic [15:0]      cmd;
    logic [7:0][15:0] ptr;
    logic [15:0]      key;
    logic [6:0]       cnt;
    logic [2:0]       bidx;
    logic [63:0]      data;
    logic             eop;
    logic             started;
    logic             rx_ready;
    logic             tx_valid;
    rra_tx_t          tx;
    logic             tx_end;
    logic             err;
    rra_acc_t         acc;
  } rra_regs_t;

  rra_regs_t q;
  rra_regs_t d;

  // ----------------------------------------------------------------
  // Info area word for a space
  // ----------------------------------------------------------------
  function automatic logic [15:0] info_word(input logic [2:0]  sp,
                                            input logic [2:0]  idx,
                                            input logic [15:0] p);
    logic [63:0] lab;
    lab = SPACE_LABELS[sp];
    unique case (idx)
      3'h0: info_word = COOKIE_BASE | {13'h0, sp};  // see R11
      3'h1: info_word = SPACE_SIZES[sp];            // see R14
      3'h2: info_word = SPACE_RANGES[sp];           // see R16
      3'h3: info_word = p;                          // see R12
      3'h4: info_word = lab[15:0];
      3'h5: info_word = lab[31:16];
      3'h6: info_word = lab[47:32];
      3'h7: info_word = lab[63:48];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        take;
    logic [2:0]  sp;
    logic [1:0]  sz;
    logic [3:0]  nb;
    logic [15:0] a;
    logic [15:0] c;
    logic [15:0] sizes;
    logic [5:0]  rexp;
    logic        ok;
    logic        oor;
    logic        abort;
    logic        send;
    logic [63:0] rd;
    d     = q;
    d.err = 1'b0;
    d.tx_end = 1'b0;
    take  = q.rx_ready && rx_valid;
    sp    = q.cmd[CMD_SPACE_HI:CMD_SPACE_LO];                  // see R5
    sz    = q.cmd[CMD_SIZE_HI:CMD_SIZE_LO];
    nb    = 4'h1 << sz;                                        // see R6
    a     = q.ptr[sp];
    c     = {rx.data, q.cmd[7:0]};                             // see R10
    sizes = SPACE_SIZES[c[CMD_SPACE_HI:CMD_SPACE_LO]];
    rexp  = SPACE_RANGES[sp][5:0];
    oor   = (rexp < 6'h10) && ((a >> rexp) != 16'h0);
    ok    = 1'b0;
    abort = 1'b0;
    send  = 1'b0;
    rd    = q.data;
    unique case (q.st)
      S_IDLE: begin
        if (rx_valid && rx.sop) begin
          d.tx.port = rx.src_port;                             // see R24
          d.eop     = 1'b0;
          d.started = 1'b0;
          d.st = (rx.dst_port == UDP_PORT) ? S_CMD_LO : S_DRAIN; // see R23
        end
      end
      S_CMD_LO: begin
        if (take) begin
          d.cmd[7:0] = rx.data;
          if (rx.eop) begin
            d.err = 1'b1;
            d.st  = S_END;
          end else begin
            d.st = S_CMD_HI;
          end
        end
      end
      S_CMD_HI: begin
        if (take) begin
          d.cmd  = c;                                          // see R1
          d.cnt  = c[CMD_COUNT_HI:0];
          d.eop  = rx.eop;
          d.bidx = 3'h0;
          if (c[CMD_INFO_BIT]) begin                           // see R4
            ok = !c[CMD_WRITE_BIT] &&
                 (c[CMD_SIZE_HI:CMD_SIZE_LO] == SZ_16);        // see R13
          end else begin
            ok = sizes[c[CMD_SIZE_HI:CMD_SIZE_LO]] &&          // see R15, R18
                 (!c[CMD_WRITE_BIT] || sizes[15]);
          end
          if (c[CMD_COUNT_HI:0] == 7'h0) begin
            ok = 1'b0;                                         // see R8
          end
          if (!ok) begin
            d.err = 1'b1;
            d.st  = rx.eop ? S_END : S_DRAIN;
          end else if (c[CMD_ADDR_BIT] || c[CMD_WRITE_BIT]) begin
            if (rx.eop) begin
              d.err = 1'b1;
              d.st  = S_END;
            end else begin
              d.st = c[CMD_ADDR_BIT] ? S_ADR_LO : S_WDATA;     // see R9
            end
          end else begin
            d.st = S_EXEC;
          end
        end
      end
      S_ADR_LO: begin
        if (take) begin
          d.ptr[sp][7:0] = rx.data;                            // see R3
          if (rx.eop) begin
            d.err = 1'b1;
            d.st  = S_END;
          end else begin
            d.st = S_ADR_HI;
          end
        end
      end
      S_ADR_HI: begin
        if (take) begin
          d.ptr[sp][15:8] = rx.data;                           // see R3
          d.eop = rx.eop;
          if (q.cmd[CMD_WRITE_BIT] && rx.eop) begin
            d.err = 1'b1;
            d.st  = S_END;
          end else begin
            d.st = q.cmd[CMD_WRITE_BIT] ? S_WDATA : S_EXEC;
          end
        end
      end
      S_WDATA: begin
        if (take) begin
          if (q.bidx == 3'h0) begin
            d.data = 64'h0;
          end
          d.data[{q.bidx, 3'h0} +: 8] = rx.data;               // see R10
          d.eop = rx.eop;
          if ({1'b0, q.bidx} == nb - 4'h1) begin
            d.bidx = 3'h0;
            d.st   = S_EXEC;
          end else if (rx.eop) begin
            d.err = 1'b1;
            d.st  = S_END;
          end else begin
            d.bidx = q.bidx + 3'h1;
          end
        end
      end
      S_EXEC: begin
        if (q.cmd[CMD_INFO_BIT]) begin
          if (a[15:4] != 12'h0) begin
            abort = 1'b1;
          end else begin
            rd   = {48'h0, info_word(sp, a[3:1], a)};          // see R12
            send = 1'b1;
          end
        end else if (oor) begin
          abort = 1'b1;                                        // see R17
        end else if (sp == KEY_SPACE && a == KEY_OFFSET) begin
          if (q.cmd[CMD_WRITE_BIT]) begin
            d.key = q.data[15:0];
            d.st  = S_NEXT;
          end else begin
            rd   = {48'h0, q.key};
            send = 1'b1;
          end
        end else if (q.cmd[CMD_WRITE_BIT] && sp == EE_SPACE &&
                     (q.key != KEY_VALUE ||                    // see R20
                      a < EE_RO_LIMIT)) begin                  // see R19
          d.err = 1'b1;
          d.st  = S_NEXT;
        end else begin
          d.acc.req   = 1'b1;
          d.acc.we    = q.cmd[CMD_WRITE_BIT];                  // see R2
          d.acc.space = sp;
          d.acc.size  = sz;
          d.acc.addr  = a;
          d.acc.wdata = q.data;
          d.st        = S_WAIT;
        end
      end
      S_WAIT: begin
        if (acc_ack) begin
          d.acc.req = 1'b0;
          if (q.cmd[CMD_WRITE_BIT]) begin
            d.st = S_NEXT;
          end else begin
            rd   = acc_rdata;
            send = 1'b1;
          end
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          if ({1'b0, q.bidx} == nb - 4'h1) begin
            d.tx_valid = 1'b0;
            d.started  = 1'b1;
            d.bidx     = 3'h0;
            d.st       = S_NEXT;
          end else begin
            d.bidx    = q.bidx + 3'h1;
            d.tx.data = q.data[{q.bidx + 3'h1, 3'h0} +: 8];    // see R10
          end
        end
      end
      S_NEXT: begin
        if (q.cmd[CMD_INC_BIT]) begin
          d.ptr[sp] = a + {12'h0, nb};                         // see R7
        end
        d.cnt = q.cnt - 7'h1;
        if (q.cnt == 7'h1) begin
          d.st = q.eop ? S_END : S_CMD_LO;                     // see R25
        end else if (q.cmd[CMD_WRITE_BIT]) begin
          if (q.eop) begin
            d.err = 1'b1;
            d.st  = S_END;
          end else begin
            d.st = S_WDATA;
          end
        end else begin
          d.st = S_EXEC;
        end
      end
      S_DRAIN: begin
        if (take && rx.eop) begin
          d.st = S_END;
        end
      end
      S_END: begin
        d.key    = KEY_RESET;                                  // see R21
        d.tx_end = q.started;                                  // see R25
        d.st     = S_IDLE;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    if (abort) begin
      d.err = 1'b1;
      d.st  = q.eop ? S_END : S_DRAIN;
    end
    if (send) begin
      d.data     = rd;
      d.tx_valid = 1'b1;
      d.tx.data  = rd[7:0];
      d.bidx     = 3'h0;
      d.st       = S_SEND;
    end
    d.rx_ready = (d.st == S_CMD_LO) || (d.st == S_CMD_HI) ||
                 (d.st == S_ADR_LO) || (d.st == S_ADR_HI) ||
                 (d.st == S_WDATA)  || (d.st == S_DRAIN);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rx_ready  = q.rx_ready;
  assign tx_valid  = q.tx_valid;
  assign tx        = q.tx;
  assign tx_end    = q.tx_end;
  assign acc       = q.acc;
  assign cmd_error = q.err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_KEY_CLEARED: assert property (  // see R21
    @(posedge clk) disable iff (rst)
    q.st == S_END |=> q.key == KEY_RESET && q.st == S_IDLE)
    else $error("key register not cleared at packet end");

  AST_EE_KEYED: assert property (  // see R20
    @(posedge clk) disable iff (rst)
    $rose(q.acc.req) && q.acc.we && q.acc.space == EE_SPACE
    |-> q.key == KEY_VALUE)
    else $error("EEPROM write issued without key");

  AST_EE_RO: assert property (  // see R19
    @(posedge clk) disable iff (rst)
    q.acc.req && q.acc.we && q.acc.space == EE_SPACE
    |-> q.acc.addr >= EE_RO_LIMIT && q.acc.size == SZ_16)
    else $error("write to read-only EEPROM area");

  AST_SPACE0_WIDTH: assert property (  // see R17
    @(posedge clk) disable iff (rst)
    q.acc.req && q.acc.space == REG_SPACE |-> q.acc.size == SZ_32)
    else $error("register space access not 32 bit");

  AST_SPACE1_WIDTH: assert property (  // see R18
    @(posedge clk) disable iff (rst)
    q.acc.req && q.acc.space == NET_SPACE |-> q.acc.size == SZ_16)
    else $error("network chip access not 16 bit");

  AST_INFO_LOCAL: assert property (  // see R13
    @(posedge clk) disable iff (rst)
    q.acc.req |-> !q.cmd[CMD_INFO_BIT] &&
                  q.acc.we == q.cmd[CMD_WRITE_BIT])
    else $error("info access or wrong direction reached access port");

  AST_PTR_STEP: assert property (  // see R7
    @(posedge clk) disable iff (rst)
    q.st == S_NEXT |=> q.ptr[$past(q.cmd[12:10])] ==
      $past(q.ptr[q.cmd[12:10]]) +
      ($past(q.cmd[CMD_INC_BIT]) ? 16'h1 << $past(q.cmd[9:8]) : 16'h0))
    else $error("pointer step wrong after transfer");

  AST_ZERO_COUNT: assert property (  // see R8
    @(posedge clk) disable iff (rst)
    q.st == S_CMD_HI && q.rx_ready && rx_valid && q.cmd[6:0] == 7'h0
    |=> q.err ##1 q.acc.req == 1'b0 && q.tx_valid == 1'b0)
    else $error("zero count not flagged");

  AST_SEND_HOLD: assert property (  // see R25
    @(posedge clk) disable iff (rst)
    q.tx_valid && !tx_ready |=> q.tx_valid && $stable(q.tx.data))
    else $error("reply byte dropped under back-pressure");

endmodule // rra_parser

`default_nettype wire

/* File: rra_host_model.sv */
// Host side model: sends command datagrams and sinks the replies
`timescale 1ns/1ps
`default_nettype none
module rra_host_model (
  input  wire logic             clk,
  output logic                  rx_valid,
  output rra_pkg::rra_rx_t      rx,
  input  wire logic             rx_ready,
  input  wire logic             tx_valid,
  input  wire rra_pkg::rra_tx_t tx,
  output logic                  tx_ready,
  input  wire logic             tx_end
);
  import rra_pkg::*;

  logic [7:0]  pkt [$];
  logic [7:0]  reply [$];
  logic [15:0] reply_port;
  logic        stall;
  int          n_end;

  initial begin
    rx_valid   = 1'b0;
    rx         = '0;
    tx_ready   = 1'b0;
    stall      = 1'b0;
    n_end      = 0;
    reply_port = 16'h0000;
  end

  // ----------------------------------------------------------------
  // Datagram sender
  // ----------------------------------------------------------------
  // Bytes leave in queue order, built LSB first by the caller
  task automatic send(input logic [15:0] dport, input logic [15:0] sport);
    int i;
    i = 0;
    while (i < pkt.size()) begin
      rx_valid <= 1'b1;
      rx <= '{sop: (i == 0), eop: (i == pkt.size() - 1), dst_port: dport,
              src_port: sport, data: pkt[i]};
      @(posedge clk);
      if (rx_ready) i++;
    end
    // Released data lines do not keep the last byte
    rx_valid <= 1'b0;
    rx       <= '{sop: 1'b0, eop: 1'b0, dst_port: ~dport, src_port: ~sport,
                  data: ~rx.data};
    pkt.delete();
  endtask

  // ----------------------------------------------------------------
  // Reply sink, stalls every other cycle when asked
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      reply.push_back(tx.data);
      reply_port <= tx.port;
    end
    if (tx_end) n_end <= n_end + 1;
    tx_ready <= stall ? ~tx_ready : 1'b1;
  end
endmodule // rra_host_model
`default_nettype wire

/* File: tb_remote_register_access_parser.sv */
// Self-checking testbench of the remote register access parser
`timescale 1ns/1ps
`default_nettype none
module tb_remote_register_access_parser;
  import rra_pkg::*;

  localparam logic [15:0] SRC = 16'h1234;
  logic        clk, rst, rx_valid, rx_ready, tx_valid, tx_ready, tx_end;
  logic        acc_ack, cmd_error, slow;
  logic [63:0] acc_rdata;
  logic [18:0] k;
  rra_rx_t     rx;
  rra_tx_t     tx;
  rra_acc_t    acc;
  logic [7:0]  mem [logic [18:0]];
  logic [63:0] acc_log [$];
  int          errors, n_checks, n_err, wait_c;
  int          sps [4] = '{0, 1, 2, 6};

  rra_parser dut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx(rx),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready),
    .tx_end(tx_end), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
    .cmd_error(cmd_error));
  rra_host_model host (.clk(clk), .rx_valid(rx_valid), .rx(rx),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready),
    .tx_end(tx_end));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] cw(input int w, a, c, sp, sz, inc, n);
    return {w[0], a[0], c[0], sp[2:0], sz[1:0], inc[0], n[6:0]};
  endfunction

  function automatic logic [63:0] ae(input logic w, input logic [2:0] sp,
      input logic [1:0] sz, input logic [15:0] a);
    return {42'h0, w, sp, sz, a};
  endfunction

  function automatic logic [63:0] rb(input int i, input int n);
    logic [63:0] v;
    v = '0;
    for (int j = 0; j < n; j++)
      v[8*j +: 8] = (i + j < host.reply.size()) ? host.reply[i+j] : 8'hxx;
    return v;
  endfunction

  task automatic p16(input logic [15:0] v);
    host.pkt.push_back(v[7:0]);
    host.pkt.push_back(v[15:8]);
  endtask

  task automatic p32(input logic [31:0] v);
    p16(v[15:0]);
    p16(v[31:16]);
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [15:0] dport);
    int idle;
    host.reply.delete();
    acc_log.delete();
    n_err = 0;
    idle = 0;
    @(posedge clk);
    host.send(dport, SRC);
    while (idle < 30) begin
      @(posedge clk);
      idle = (acc.req || tx_valid) ? 0 : idle + 1;
    end
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Access port responder, fast and slow in turn
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (cmd_error) n_err <= n_err + 1;
    acc_ack <= 1'b0;
    if (acc.req && !acc_ack) begin
      if (wait_c >= (slow ? 3 : 0)) begin
        for (int j = 0; j < (1 << acc.size); j++) begin
          k = {acc.space, acc.addr + 16'(j)};
          if (acc.we) mem[k] = acc.wdata[8*j +: 8];
          acc_rdata[8*j +: 8] <= mem.exists(k) ? mem[k] : 8'h00;
        end
        acc_log.push_back(ae(acc.we, acc.space, acc.size, acc.addr));
        acc_ack <= 1'b1;
        wait_c <= 0;
        slow <= ~slow;
      end else begin
        wait_c <= wait_c + 1;
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    acc_ack = 1'b0;
    acc_rdata = '0;
    slow = 1'b0;
    wait_c = 0;
    errors = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);

    // Block write, block read, then read on from the kept pointer
    host.stall = 1'b1;
    p16(cw(1, 1, 0, 0, SZ_32, 1, 3));
    p16(16'h1000);
    p32(32'hA1B2C3D4);
    p32(32'h11223344);
    p32(32'h55667788);
    p16(cw(0, 1, 0, 0, SZ_32, 1, 2));
    p16(16'h1000);
    p16(cw(0, 0, 0, 0, SZ_32, 1, 1));
    run(UDP_PORT);
    chk(64'(acc_log.size()), 64'd6);
    for (int i = 0; i < 6; i++)
      chk(acc_log[i], ae(i < 3, 3'h0, SZ_32, 16'h1000 + 16'(4 * (i % 3))));
    chk(rb(0, 4), 64'hA1B2C3D4);
    chk(rb(4, 4), 64'h11223344);
    chk(rb(8, 4), 64'h55667788);
    chk(64'(host.reply_port), 64'(SRC));
    chk(64'(host.n_end), 64'd1);
    host.stall = 1'b0;
    $display("block access test done");

    // Info area of each implemented space
    foreach (sps[s]) begin
      p16(cw(0, 1, 1, 3'(sps[s]), SZ_16, 1, 8));
      p16(16'h0000);
      run(UDP_PORT);
      chk(rb(0, 2), 64'(COOKIE_BASE | 16'(sps[s])));
      chk(rb(2, 2), 64'(SPACE_SIZES[sps[s]]));
      chk(rb(4, 2), 64'(SPACE_RANGES[sps[s]]));
      chk(rb(6, 2), 64'h0006);
      chk(rb(8, 8), SPACE_LABELS[sps[s]]);
      chk(64'(acc_log.size()), 64'd0);
    end
    $display("info area test done");

    // Refused: zero count, info write, wide info, narrow net chip, range
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: p16(cw(0, 1, 0, 0, SZ_32, 1, 0));
        1: p16(cw(1, 1, 1, 0, SZ_16, 1, 1));
        2: p16(cw(0, 1, 1, 0, SZ_32, 1, 1));
        3: p16(cw(0, 1, 0, 1, SZ_8, 1, 1));
        default: p16(cw(0, 1, 0, 1, SZ_16, 1, 1));
      endcase
      p16((i == 4) ? 16'h0100 : 16'h0000);
      p16(16'h0000);
      run(UDP_PORT);
      chk(64'(n_err), 64'd1);
      chk(64'(acc_log.size()), 64'd0);
    end
    // Fixed pointer on the net chip space
    p16(cw(0, 1, 0, 1, SZ_16, 0, 2));
    p16(16'h00C0);
    run(UDP_PORT);
    chk(acc_log[0], ae(1'b0, 3'h1, SZ_16, 16'h00C0));
    chk(acc_log[1], ae(1'b0, 3'h1, SZ_16, 16'h00C0));
    $display("refusal test done");

    // EEPROM: no key, key then writes, key gone in the next datagram
    for (int i = 0; i < 3; i++) begin
      if (i == 1) begin
        p16(cw(1, 1, 0, 6, SZ_16, 1, 1));
        p16(KEY_OFFSET);
        p16(KEY_VALUE);
      end
      p16(cw(1, 1, 0, 2, SZ_16, 1, 2));
      p16(16'h0020 + 16'(4 * i));
      p16(16'hC0A8 + 16'(i));
      p16(16'h0020);
      p16(cw(1, 1, 0, 2, SZ_16, 1, 1));
      p16(16'h0010);
      p16(16'hDEAD);
      p16(cw(0, 1, 0, 2, SZ_16, 1, 1));
      p16(16'h0020 + 16'(4 * i));
      run(UDP_PORT);
      chk(64'(n_err), (i == 1) ? 64'd1 : 64'd3);
      chk(64'(acc_log.size()), (i == 1) ? 64'd3 : 64'd1);
      chk(rb(0, 2), (i == 1) ? 64'hC0A9 : 64'h0000);
    end
    $display("eeprom key test done");

    // Datagram to a foreign port has no effect
    p16(cw(1, 1, 0, 0, SZ_32, 1, 1));
    p16(16'h2000);
    p32(32'hCAFEF00D);
    run(UDP_PORT + 16'h0001);
    chk(64'(acc_log.size()), 64'd0);
    chk(64'(host.reply.size()), 64'd0);
    $display("port filter test done");
    test_done();
  end
endmodule // tb_remote_register_access_parser
`default_nettype wire
